/* File: tsc_top.v */
`timescale 1ns/1ps
`include "tsc_map.vh"

module tsc_top #(
  parameter [`TSC_TMR_W-1:0] CONV_CYC = `TSC_CONV_CYC,
  parameter [`TSC_TMR_W-1:0] NV_CYC   = `TSC_NV_CYC
) (
  // Clock and reset
  input  wire       I_CLK,
  input  wire       I_RST,
  // Three-wire port
  input  wire       I_SEL,
  input  wire       I_CLOCK_OR_CONVERT_PIN,
  input  wire       I_DQ,
  output reg        O_DQ,
  output reg        O_DQ_OE,
  // Measurement core
  input  wire [8:0] I_MEAS_TEMP,
  input  wire [8:0] I_MEAS_COUNT,
  input  wire [8:0] I_MEAS_SLOPE,
  output reg        O_MEAS_RUN,
  // Thermostat outputs
  output reg        O_T_HIGH,
  output reg        O_T_LOW,
  output reg        O_T_COM
);

  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  wire [2:0] pin_lvl;
  wire       sel;
  wire       sclk;
  wire       dq_in;
  reg        sclk_q;
  reg        sa_hold_q;

  tsc_sync #(
    .W       (3),
    .RST_VAL (`TSC_RST_PINS)
  ) u_sync (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_pin ({I_CLOCK_OR_CONVERT_PIN, I_DQ, I_SEL}),
    .o_lvl (pin_lvl)
  );

  assign sel   = pin_lvl[0];
  assign dq_in = pin_lvl[1];
  assign sclk  = pin_lvl[2];

  wire sclk_rise = sclk & ~sclk_q;
  wire sclk_fall = ~sclk & sclk_q;

  // ****************************************
  // Configuration and measurement state
  // ****************************************
  reg [8:0]  upper_limit;
  reg [8:0]  lower_limit;
  reg [8:0]  temp_val;
  reg [8:0]  count_val;
  reg [8:0]  slope_val;
  reg        done;
  reg        high_limit_flag;
  reg        low_limit_flag;
  reg        nv_write_busy;
  reg        host_sel;
  reg        single_conversion_mode;

  wire [7:0] cfg_rd;

  // Status word; bits 3 and 2 are fixed
  assign cfg_rd = {done, high_limit_flag, low_limit_flag, nv_write_busy,
                   1'b1, 1'b0, host_sel, single_conversion_mode};

  // Stand-alone convert request, gated by host-select
  wire sa_hold;
  assign sa_hold = ~host_sel & ~sel & ~sclk;

  // Edge history of clock pin and stand-alone request
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sclk_q    <= 1'b1;
      sa_hold_q <= 1'b0;
    end else begin
      sclk_q    <= sclk;
      sa_hold_q <= sa_hold;
    end
  end

  // ****************************************
  // Serial command engine
  // ****************************************
  reg  [4:0] bit_cnt;
  reg  [7:0] cmd;
  reg  [8:0] rd_sh;
  reg  [8:0] wr_sh;
  reg        is_rd;
  reg        st_start;
  reg        st_stop;
  reg        st_wr_upper;
  reg        st_wr_lower;
  reg        st_wr_cfg;
  reg  [8:0] wr_val;

  // Both shifters take the new bit at the top: LSB first
  wire [7:0] next_cmd = {dq_in, cmd[7:1]};
  wire [8:0] next_wr  = {dq_in, wr_sh[8:1]};

  // Command decode, data shifting and data line drive
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      bit_cnt     <= 5'h00;
      cmd         <= 8'h00;
      rd_sh       <= 9'h000;
      wr_sh       <= 9'h000;
      is_rd       <= 1'b0;
      O_DQ        <= 1'b0;
      O_DQ_OE     <= 1'b0;
      st_start    <= 1'b0;
      st_stop     <= 1'b0;
      st_wr_upper <= 1'b0;
      st_wr_lower <= 1'b0;
      st_wr_cfg   <= 1'b0;
      wr_val      <= 9'h000;
    end else begin
      st_start    <= 1'b0;
      st_stop     <= 1'b0;
      st_wr_upper <= 1'b0;
      st_wr_lower <= 1'b0;
      st_wr_cfg   <= 1'b0;
      if (!sel) begin
        // Select low aborts the transfer and floats the line
        bit_cnt <= 5'h00;
        is_rd   <= 1'b0;
        O_DQ_OE <= 1'b0;
      end else if (sclk_rise) begin
        // Input bit sampled on rising edge; line released
        O_DQ_OE <= 1'b0;
        if (bit_cnt != `TSC_CNT_MAX) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
        if (bit_cnt < `TSC_CMD_BITS) begin
          cmd <= next_cmd;
          if (bit_cnt == `TSC_CMD_BITS - 5'h01) begin
            is_rd <= 1'b1;
            case (next_cmd)
              `TSC_CMD_RD_TEMP:  rd_sh <= temp_val;
              `TSC_CMD_RD_COUNT: rd_sh <= count_val;
              `TSC_CMD_RD_SLOPE: rd_sh <= slope_val;
              `TSC_CMD_RD_UPPER: rd_sh <= upper_limit;
              `TSC_CMD_RD_LOWER: rd_sh <= lower_limit;
              `TSC_CMD_RD_CFG:   rd_sh <= {1'b0, cfg_rd};
              default: begin
                is_rd <= 1'b0;
                rd_sh <= 9'h000;
              end
            endcase
            st_start <= (next_cmd == `TSC_CMD_START);
            st_stop  <= (next_cmd == `TSC_CMD_STOP);
          end
        end else begin
          wr_sh <= next_wr;
          // Commit only when the last data bit arrives
          if (bit_cnt == `TSC_LAST_VAL_BIT) begin
            wr_val      <= next_wr;
            st_wr_upper <= (cmd == `TSC_CMD_WR_UPPER);
            st_wr_lower <= (cmd == `TSC_CMD_WR_LOWER);
          end
          if (bit_cnt == `TSC_LAST_CFG_BIT) begin
            wr_val    <= {1'b0, next_wr[8:1]};
            st_wr_cfg <= (cmd == `TSC_CMD_WR_CFG);
          end
        end
      end else if (sclk_fall && is_rd && bit_cnt >= `TSC_CMD_BITS) begin
        // Drive next bit after falling edge; zeros refill
        O_DQ    <= rd_sh[0];
        O_DQ_OE <= 1'b1;
        rd_sh   <= {1'b0, rd_sh[8:1]};
      end
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_LAST = 3'b100;

  reg [2:0]            state;
  reg [`TSC_TMR_W-1:0] conv_cnt;
  reg [`TSC_TMR_W-1:0] nv_cnt;
  reg                  cont;

  wire sa_start  = sa_hold & ~sa_hold_q;
  wire start_req = st_start | sa_start;
  wire conv_end  = (state != ST_IDLE) && (conv_cnt == CONV_CYC - 1'b1);
  // Keep running in continuous mode or while pin held low
  wire go_on     = ((state == ST_CONV) & cont) | sa_hold;

  // Signed results compared with limits
  wire at_high = $signed(I_MEAS_TEMP) >= $signed(upper_limit);
  wire at_low  = $signed(I_MEAS_TEMP) <= $signed(lower_limit);

  // Sequencing, result capture, flags and thermostat outputs
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state      <= ST_IDLE;
      conv_cnt   <= {`TSC_TMR_W{1'b0}};
      cont       <= 1'b0;
      done       <= 1'b0;
      temp_val   <= 9'h000;
      count_val  <= 9'h000;
      slope_val  <= 9'h000;
      O_MEAS_RUN <= 1'b0;
      O_T_HIGH   <= 1'b0;
      O_T_LOW    <= 1'b0;
      O_T_COM    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            // One-shot unless continuous mode requested
            state      <= ST_CONV;
            conv_cnt   <= {`TSC_TMR_W{1'b0}};
            cont       <= st_start & ~single_conversion_mode;
            done       <= 1'b0;
            O_MEAS_RUN <= 1'b1;
          end
        end
        ST_CONV, ST_LAST: begin
          if (st_stop) begin
            state <= ST_LAST;
          end
          if (start_req && !st_stop) begin
            state <= ST_CONV;
            cont  <= st_start & ~single_conversion_mode;
          end
          if (conv_end) begin
            temp_val  <= I_MEAS_TEMP;
            count_val <= I_MEAS_COUNT;
            slope_val <= I_MEAS_SLOPE;
            done      <= 1'b1;
            // Outputs change only at a conversion end
            O_T_HIGH  <= at_high;
            O_T_LOW   <= at_low;
            if (at_high) begin
              O_T_COM <= 1'b1;
            end else if (at_low) begin
              O_T_COM <= 1'b0;
            end
            conv_cnt  <= {`TSC_TMR_W{1'b0}};
            if (go_on && !st_stop) begin
              state <= ST_CONV;
            end else begin
              state      <= ST_IDLE;
              O_MEAS_RUN <= 1'b0;
            end
          end else begin
            conv_cnt <= conv_cnt + 1'b1;
          end
        end
        default: begin
          state      <= ST_IDLE;
          O_MEAS_RUN <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Configuration, limits and limit flags
  // ****************************************
  wire cell_write = st_wr_upper | st_wr_lower | st_wr_cfg;

  // Host writes, nonvolatile busy timer and sticky flags
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      upper_limit            <= `TSC_RST_UPPER;
      lower_limit            <= `TSC_RST_LOWER;
      host_sel               <= `TSC_RST_HOST_SEL;
      single_conversion_mode <= `TSC_RST_SINGLE;
      high_limit_flag        <= 1'b0;
      low_limit_flag         <= 1'b0;
      nv_write_busy          <= 1'b0;
      nv_cnt                 <= {`TSC_TMR_W{1'b0}};
    end else begin
      if (st_wr_upper) begin
        upper_limit <= wr_val;
      end
      if (st_wr_lower) begin
        lower_limit <= wr_val;
      end
      if (st_wr_cfg) begin
        // Done and busy bits are not writable
        host_sel               <= wr_val[`TSC_CFG_HOST_SEL];
        single_conversion_mode <= wr_val[`TSC_CFG_SINGLE];
      end
      // Writing 0 clears; a same-cycle set wins
      if (conv_end && at_high) begin
        high_limit_flag <= 1'b1;
      end else if (st_wr_cfg && !wr_val[`TSC_CFG_HIGH_FLAG]) begin
        high_limit_flag <= 1'b0;
      end
      if (conv_end && at_low) begin
        low_limit_flag <= 1'b1;
      end else if (st_wr_cfg && !wr_val[`TSC_CFG_LOW_FLAG]) begin
        low_limit_flag <= 1'b0;
      end
      // Cell write time, restarted by each committed write
      if (cell_write) begin
        nv_write_busy <= 1'b1;
        nv_cnt        <= {`TSC_TMR_W{1'b0}};
      end else if (nv_write_busy) begin
        if (nv_cnt == NV_CYC - 1'b1) begin
          nv_write_busy <= 1'b0;
        end else begin
          nv_cnt <= nv_cnt + 1'b1;
        end
      end
    end
  end

endmodule // tsc_top

/* File: tsc_map.vh */
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

// ****************************************
// Clock and timing
// ****************************************
`define TSC_CLK_HZ        50000000
`define TSC_CONV_TIME_MS  1000
`define TSC_NV_TIME_MS    10
// Longest times in whole cycles at the clock above, sized to the timer
`define TSC_CONV_CYC      26'h2FA_F080
`define TSC_NV_CYC        26'h7_A120
`define TSC_TMR_W         26

// ****************************************
// Serial framing
// ****************************************
`define TSC_CMD_BITS      5'h08
`define TSC_LAST_CFG_BIT  5'h0F
`define TSC_LAST_VAL_BIT  5'h10
`define TSC_CNT_MAX       5'h1F

// ****************************************
// Command codes
// ****************************************
`define TSC_CMD_RD_TEMP   8'hAA
`define TSC_CMD_RD_COUNT  8'hA0
`define TSC_CMD_RD_SLOPE  8'hA9
`define TSC_CMD_WR_UPPER  8'h01
`define TSC_CMD_WR_LOWER  8'h02
`define TSC_CMD_RD_UPPER  8'hA1
`define TSC_CMD_RD_LOWER  8'hA2
`define TSC_CMD_START     8'hEE
`define TSC_CMD_STOP      8'h22
`define TSC_CMD_WR_CFG    8'h0C
`define TSC_CMD_RD_CFG    8'hAC

// ****************************************
// Configuration/status bit positions
// ****************************************
`define TSC_CFG_DONE      7
`define TSC_CFG_HIGH_FLAG 6
`define TSC_CFG_LOW_FLAG  5
`define TSC_CFG_NV_BUSY   4
`define TSC_CFG_FIX1      3
`define TSC_CFG_FIX0      2
`define TSC_CFG_HOST_SEL  1
`define TSC_CFG_SINGLE    0

// ****************************************
// Reset values
// ****************************************
`define TSC_RST_HOST_SEL  1'b0
`define TSC_RST_SINGLE    1'b0
`define TSC_RST_UPPER     9'h000
`define TSC_RST_LOWER     9'h000
`define TSC_RST_PINS      3'h6

`endif

/* File: tsc_sync.v */
`timescale 1ns/1ps

// ****************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************
module tsc_sync #(
  parameter         W       = 3,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rst,
  // Pin side
  input  wire [W-1:0] i_pin,
  // Filtered level
  output reg  [W-1:0] o_lvl
);

  reg [W-1:0] ff1;
  reg [W-1:0] ff2;
  reg [W-1:0] ff3;

  // Shift chain; a bit changes once stages two and three agree
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ff1   <= RST_VAL;
      ff2   <= RST_VAL;
      ff3   <= RST_VAL;
      o_lvl <= RST_VAL;
    end else begin
      ff1   <= i_pin;
      ff2   <= ff1;
      ff3   <= ff2;
      o_lvl <= (ff2 & ff3) | (o_lvl & (ff2 ^ ff3));
    end
  end

endmodule // tsc_sync

/* File: tsc_top_sva.sv */
`timescale 1ns/1ps
`include "tsc_map.vh"

// ****************************************
// Port checker for the command block
// ****************************************
module tsc_chk #(
  parameter [`TSC_TMR_W-1:0] CONV_CYC = `TSC_CONV_CYC,
  parameter [`TSC_TMR_W-1:0] NV_CYC   = `TSC_NV_CYC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Three-wire port
  input wire logic I_SEL,
  input wire logic I_CLOCK_OR_CONVERT_PIN,
  input wire logic O_DQ,
  input wire logic O_DQ_OE,
  // Conversion and thermostat
  input wire logic O_MEAS_RUN,
  input wire logic O_T_HIGH,
  input wire logic O_T_LOW,
  input wire logic O_T_COM
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  logic [31:0] run_len;

  // Length of the current conversion run
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) run_len <= 32'h0000_0000;
    else if (O_MEAS_RUN) run_len <= run_len + 32'h0000_0001;
    else run_len <= 32'h0000_0000;
  end

  a_sel_low_float: assert property (!I_SEL [*7] |-> !O_DQ_OE)
    else $error("data driven with select low");
  a_clk_high_float: assert property (
    $rose(I_CLOCK_OR_CONVERT_PIN) |-> ##5 !O_DQ_OE)
    else $error("data still driven after clock rise");
  a_drive_in_low: assert property ($rose(O_DQ_OE) |->
    !$past(I_CLOCK_OR_CONVERT_PIN, 4) && $past(I_SEL, 4))
    else $error("drive started outside a low clock phase");
  a_dq_hold: assert property (
    O_DQ_OE && $past(O_DQ_OE) |-> $stable(O_DQ))
    else $error("output bit changed while driven");
  a_thermo_at_end: assert property (
    !$stable(O_T_HIGH) || !$stable(O_T_LOW) || !$stable(O_T_COM) |->
    $past(O_MEAS_RUN) || $past(O_MEAS_RUN, 2))
    else $error("thermostat output changed without a conversion");
  a_com_with_high: assert property ($rose(O_T_COM) |-> O_T_HIGH)
    else $error("combined output set below upper limit");
  a_low_clears_com: assert property (
    $rose(O_T_LOW) && !O_T_HIGH |-> !O_T_COM)
    else $error("combined output kept at lower limit");
  a_run_full: assert property (
    $fell(O_MEAS_RUN) |-> run_len + 32'h0000_0002 >= CONV_CYC)
    else $error("conversion ended early");
endmodule // tsc_chk

bind tsc_top tsc_chk #(.CONV_CYC(CONV_CYC), .NV_CYC(NV_CYC)) u_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_SEL(I_SEL), .I_CLOCK_OR_CONVERT_PIN(I_CLOCK_OR_CONVERT_PIN),
  .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_MEAS_RUN(O_MEAS_RUN),
  .O_T_HIGH(O_T_HIGH), .O_T_LOW(O_T_LOW), .O_T_COM(O_T_COM));

/* File: tsc_host.sv */
`timescale 1ns/1ps

// ****************************************
// Host model driving the three-wire port
// ****************************************
module tsc_host (
  // System clock
  input  wire logic i_clk,
  // Device data pin
  input  wire logic i_dq,
  input  wire logic i_dq_oe,
  // Port pins
  output logic      o_sel,
  output logic      o_sck,
  output logic      o_dq
);
  localparam int H = 4; // Half bit period in system clocks, 160 ns link

  logic drv;
  logic val;

  // Wire level: device, host, else the pull-up
  assign o_dq = i_dq_oe ? i_dq : (drv ? val : 1'b1);

  // Idle pins: deselected, clock high
  initial begin
    o_sel = 1'b0;
    o_sck = 1'b1;
    drv = 1'b0;
    val = 1'b0;
  end

  task automatic half();
    repeat (H) @(posedge i_clk);
  endtask

  // Frame: command, then n data bits written or read
  task automatic xfer(input logic [7:0] cmd, input logic [9:0] wd,
                      input int n, input bit wr, output logic [9:0] rd);
    logic [17:0] bits;
    bits = {wd, cmd};
    rd = 10'h000;
    o_sel <= 1'b1;
    half();
    for (int i = 0; i < 8 + n; i++) begin
      o_sck <= 1'b0;
      drv <= (i < 8) || wr;
      val <= bits[i];
      half();
      o_sck <= 1'b1;
      half();
      // Device answers about five clocks after the pin falls, later than
      // the rise at this rate, so the bit is taken as the high phase ends
      if (i >= 8) rd[i-8] = o_dq;
    end
    o_sel <= 1'b0;
    drv <= 1'b0;
    half();
    half();
  endtask

  // Convert pin held low for n clocks with select low
  task automatic pulse(input int n);
    o_sck <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_sck <= 1'b1;
    half();
  endtask
endmodule // tsc_host

/* File: tsc_top_tb.sv */
`timescale 1ns/1ps
`include "tsc_map.vh"

// ****************************************
// Bench for the thermometer command block
// ****************************************
module tsc_top_tb;
  localparam logic [`TSC_TMR_W-1:0] CONV = 26'h0C8;
  localparam logic [`TSC_TMR_W-1:0] NV   = 26'h7D0;

  logic       clk;
  logic       rst;
  logic [8:0] temp;
  logic [8:0] cnt;
  logic [8:0] slope;
  logic [9:0] rd;
  wire        sel, sck, dq, dq_o, dq_oe, run, t_hi, t_lo, t_com;
  int         errors;
  int         total_checks;

  tsc_top #(.CONV_CYC(CONV), .NV_CYC(NV)) uut (
    .I_CLK(clk), .I_RST(rst), .I_SEL(sel), .I_CLOCK_OR_CONVERT_PIN(sck), .I_DQ(dq),
    .O_DQ(dq_o), .O_DQ_OE(dq_oe), .I_MEAS_TEMP(temp), .I_MEAS_COUNT(cnt),
    .I_MEAS_SLOPE(slope), .O_MEAS_RUN(run), .O_T_HIGH(t_hi),
    .O_T_LOW(t_lo), .O_T_COM(t_com));
  tsc_host host (.i_clk(clk), .i_dq(dq_o), .i_dq_oe(dq_oe), .o_sel(sel),
    .o_sck(sck), .o_dq(dq));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [9:0] seen,
                     input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Write then leave the storage time before the next write
  task automatic wr(input logic [7:0] cmd, input logic [9:0] v, input int n);
    host.xfer(cmd, v, n, 1'b1, rd);
    repeat (NV + 10) @(posedge clk);
  endtask

  task automatic rdcfg(input logic [7:0] exp);
    host.xfer(8'hAC, 10'h000, 8, 1'b0, rd);
    chk("config", rd, {2'b00, exp});
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end

  // Test sequence
  initial begin
    rst = 1'b1;
    temp = 9'h060;
    cnt = 9'h0A5;
    slope = 9'h15A;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdcfg(8'h08);
    $display("test reset done");
    host.xfer(8'h01, 10'h050, 9, 1'b1, rd);
    rdcfg(8'h18);
    repeat (NV) @(posedge clk);
    rdcfg(8'h08);
    wr(8'h02, 10'h014, 9);
    host.xfer(8'h01, 10'h1FF, 5, 1'b1, rd);
    host.xfer(8'hA1, 10'h000, 9, 1'b0, rd);
    chk("upper limit", rd, 10'h050);
    host.xfer(8'hA2, 10'h000, 9, 1'b0, rd);
    chk("lower limit", rd, 10'h014);
    $display("test limits done");
    wr(8'h0C, 10'h0FF, 8);
    rdcfg(8'h0B);
    host.xfer(8'hEE, 10'h000, 0, 1'b0, rd);
    chk("run", run, 10'h001);
    repeat (CONV) @(posedge clk);
    chk("run", run, 10'h000);
    chk("thermostat", {t_hi, t_lo, t_com}, 10'h005);
    rdcfg(8'hCB);
    for (int k = 0; k < 3; k++) begin
      host.xfer(k == 0 ? 8'hAA : k == 1 ? 8'hA0 : 8'hA9, 10'h000, 10,
                1'b0, rd);
      chk("result", rd,
          {1'b0, k == 0 ? temp : k == 1 ? cnt : slope});
    end
    @(posedge clk);
    temp <= 9'h1F0;
    repeat (2 * CONV) @(posedge clk);
    chk("thermostat held", {t_hi, t_lo, t_com}, 10'h005);
    wr(8'h0C, 10'h00B, 8);
    rdcfg(8'h8B);
    $display("test single done");
    wr(8'h0C, 10'h002, 8);
    host.xfer(8'hEE, 10'h000, 0, 1'b0, rd);
    repeat (2 * CONV) @(posedge clk);
    chk("run", run, 10'h001);
    chk("thermostat", {t_hi, t_lo, t_com}, 10'h002);
    rdcfg(8'hAA);
    host.xfer(8'h22, 10'h000, 0, 1'b0, rd);
    repeat (CONV + 10) @(posedge clk);
    chk("run", run, 10'h000);
    $display("test continuous done");
    wr(8'h0C, 10'h001, 8);
    host.pulse(20);
    chk("run", run, 10'h001);
    repeat (CONV + 10) @(posedge clk);
    chk("run", run, 10'h000);
    host.pulse(5 * CONV / 2);
    chk("run", run, 10'h001);
    repeat (CONV + 10) @(posedge clk);
    chk("run", run, 10'h000);
    wr(8'h0C, 10'h003, 8);
    host.pulse(20);
    chk("run", run, 10'h000);
    rdcfg(8'h8B);
    $display("test stand-alone done");
    complete_run();
  end
endmodule // tsc_top_tb
